// [logic/uvm_pkg_defs.sv]
// Package of pin groups, modes and timing constants for the memory programmer.
`default_nettype none
package uvmc_pkg;

  // Array geometry, erased value and pulse limits.
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] MAX_EXPRESS_PULSES = 4'hA;
  localparam logic [3:0] FAST_MAX_PULSES = 4'hF;

  // Clock rate and documented times.
  localparam int CLK_MHZ = 100;
  localparam int SETUP_US = 2;
  localparam int EXPRESS_PULSE_US = 100;
  localparam int FAST_PULSE_US = 1000;
  localparam int OVERPROG_PER_ITER_US = 3000;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int EXPRESS_PULSE_CYC = EXPRESS_PULSE_US * CLK_MHZ;
  localparam int FAST_PULSE_CYC = FAST_PULSE_US * CLK_MHZ;
  localparam int OVERPROG_CYC = OVERPROG_PER_ITER_US * CLK_MHZ;
  localparam int CNT_W = 32;

  // Host command codes.
  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_PROG_FAST = 3'h1,
    CMD_PROG_EXPRESS = 3'h2,
    CMD_IDENTITY = 3'h3,
    CMD_STANDBY = 3'h4
  } uvmc_cmd_t;

  // Control pins driven toward the memory.
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic program_strobe_n;
    logic high_voltage_level;
    logic identity_trigger_line;
    logic [ADDR_W-1:0] address_pins;
  } uvmc_pins_t;

  // Host request.
  typedef struct packed {
    uvmc_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } uvmc_req_t;

endpackage
`default_nettype wire

// [logic/uvmc_timer.sv]
// Down-counting delay timer that pulses done when a loaded count expires.
`default_nettype none
module uvmc_timer
  import uvmc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Load and expiry.
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic done_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic done;
  } uvmc_tmr_state_t;

  uvmc_tmr_state_t s_q;
  uvmc_tmr_state_t s_d;

  // A load restarts the count; done fires one cycle after it reaches one.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load_in) begin
      s_d.cnt = count_in;
      s_d.run = 1'b1;
    end else if (s_q.run) begin
      if (s_q.cnt <= 32'h1) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 32'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_out = s_q.done;

endmodule
`default_nettype wire

// [logic/uvmc_ctrl.sv]
// Programmer that drives a UV-erasable byte memory through its pins.
`default_nettype none
// How it works
// - Fast algorithm: 1 ms pulses, then one overprogram pulse.
// - Express: 100 us pulses, at most ten, stop on verify, no overprogram.
// - Address and data set up, then one low-going strobe pulse.
// - Verify with supply high, select low, strobe high, gate low.
module uvmc_ctrl
  import uvmc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Host request and answer.
  input wire logic req_valid_in,
  input wire uvmc_req_t req_in,
  output logic req_ready_out,
  output logic done_out,
  output logic fail_out,
  output logic [DATA_W-1:0] rdata_out,
  // Memory pins.
  output uvmc_pins_t pins_out,
  output logic [DATA_W-1:0] data_pins_out,
  output logic data_pins_oe_out,
  input wire logic [DATA_W-1:0] data_pins_in
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SETUP = 4'h1,
    ST_GATE = 4'h2,
    ST_SAMPLE = 4'h3,
    ST_PSETUP = 4'h4,
    ST_PULSE = 4'h5,
    ST_PHOLD = 4'h6,
    ST_VGATE = 4'h7,
    ST_VCHECK = 4'h8,
    ST_OVER = 4'h9,
    ST_FINISH = 4'hA
  } uvmc_state_t;

  typedef struct packed {
    uvmc_state_t st;
    uvmc_req_t req;
    logic [3:0] tries;
    logic ready;
    logic done;
    logic fail;
    logic [DATA_W-1:0] rdata;
    uvmc_pins_t pins;
    logic [DATA_W-1:0] dout;
    logic doe;
  } uvmc_ctrl_state_t;

  uvmc_ctrl_state_t s_q;
  uvmc_ctrl_state_t s_d;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;

  // Inhibited idle pin state: everything deasserted and supply at read level.
  function automatic uvmc_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    uvmc_pins_t p;
    p.chip_sel_n = 1'b1;
    p.out_gate_n = 1'b1;
    p.program_strobe_n = 1'b1;
    p.high_voltage_level = 1'b0;
    p.identity_trigger_line = 1'b0;
    p.address_pins = a;
    return p;
  endfunction

  // Pulse length chosen by algorithm; fast overprogram scales with tries.
  function automatic logic [CNT_W-1:0] pulse_len(input uvmc_cmd_t c);
    return (c == CMD_PROG_EXPRESS) ? CNT_W'(EXPRESS_PULSE_CYC)
                                   : CNT_W'(FAST_PULSE_CYC);
  endfunction

  uvmc_timer u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  // Sequencer. Every step except ST_IDLE and ST_SAMPLE waits on the timer so set-up times are met.
  always_comb begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_count = CNT_W'(SETUP_CYC);
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        s_d.pins = idle_pins(s_q.req.addr);
        s_d.doe = 1'b0;
        if (req_valid_in && s_q.ready) begin
          s_d.req = req_in;
          s_d.ready = 1'b0;
          s_d.fail = 1'b0;
          s_d.tries = 4'h0;
          s_d.pins.address_pins = req_in.addr;
          tmr_load = 1'b1;
          case (req_in.cmd)
            CMD_STANDBY: begin
              s_d.st = ST_FINISH;
            end
            CMD_PROG_FAST, CMD_PROG_EXPRESS: begin
              // Blank check first; a target needing a zero-to-one fails.
              s_d.pins.high_voltage_level = 1'b1;
              s_d.st = ST_SETUP;
            end
            CMD_IDENTITY: begin
              s_d.pins.identity_trigger_line = 1'b1;
              s_d.pins.address_pins = {{(ADDR_W-1){1'b0}},
                                       req_in.addr[0]};
              s_d.st = ST_SETUP;
            end
            default: begin
              s_d.st = ST_SETUP;
            end
          endcase
        end
      end
      ST_SETUP: begin
        s_d.pins.chip_sel_n = 1'b0;
        if (tmr_done) begin
          tmr_load = 1'b1;
          s_d.st = ST_GATE;
        end
      end
      ST_GATE: begin
        s_d.pins.out_gate_n = 1'b0;
        if (tmr_done) begin
          s_d.st = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        s_d.rdata = data_pins_in;
        s_d.pins.out_gate_n = 1'b1;
        tmr_load = 1'b1;
        if (s_q.req.cmd == CMD_PROG_FAST ||
            s_q.req.cmd == CMD_PROG_EXPRESS) begin
          if ((data_pins_in & s_q.req.data) != s_q.req.data) begin
            s_d.fail = 1'b1;
            s_d.st = ST_FINISH;
          end else if (data_pins_in == s_q.req.data) begin
            s_d.st = ST_FINISH;
          end else begin
            s_d.st = ST_PSETUP;
          end
        end else begin
          s_d.st = ST_FINISH;
        end
      end
      ST_PSETUP: begin
        // Gate is high, so the memory floats and we may drive data.
        s_d.dout = s_q.req.data;
        s_d.doe = 1'b1;
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = pulse_len(s_q.req.cmd);
          s_d.pins.program_strobe_n = 1'b0;
          s_d.tries = s_q.tries + 4'h1;
          s_d.st = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          s_d.pins.program_strobe_n = 1'b1;
          s_d.st = ST_PHOLD;
        end
      end
      ST_PHOLD: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          s_d.doe = 1'b0;
          s_d.st = ST_VGATE;
        end
      end
      ST_VGATE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          s_d.pins.out_gate_n = 1'b0;
          s_d.st = ST_VCHECK;
        end
      end
      ST_VCHECK: begin
        if (tmr_done) begin
          s_d.rdata = data_pins_in;
          s_d.pins.out_gate_n = 1'b1;
          tmr_load = 1'b1;
          if (data_pins_in == s_q.req.data) begin
            if (s_q.req.cmd == CMD_PROG_FAST) begin
              s_d.st = ST_OVER;
            end else begin
              s_d.st = ST_FINISH;
            end
          end else if ((s_q.req.cmd == CMD_PROG_EXPRESS &&
                        s_q.tries >= MAX_EXPRESS_PULSES) ||
                       s_q.tries >= FAST_MAX_PULSES) begin
            s_d.fail = 1'b1;
            s_d.st = ST_FINISH;
          end else begin
            s_d.st = ST_PSETUP;
          end
        end
      end
      ST_OVER: begin
        // One overprogram pulse, length grows with the pulses needed.
        s_d.dout = s_q.req.data;
        s_d.doe = 1'b1;
        if (tmr_done) begin
          if (s_q.pins.program_strobe_n) begin
            tmr_load = 1'b1;
            tmr_count = CNT_W'(OVERPROG_CYC) * CNT_W'(s_q.tries);
            s_d.pins.program_strobe_n = 1'b0;
          end else begin
            tmr_load = 1'b1;
            s_d.pins.program_strobe_n = 1'b1;
            s_d.st = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        if (tmr_done) begin
          s_d.pins = idle_pins(s_q.req.addr);
          s_d.doe = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_q.st <= ST_IDLE;
      s_q.req <= '0;
      s_q.tries <= 4'h0;
      s_q.ready <= 1'b0;
      s_q.done <= 1'b0;
      s_q.fail <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.pins <= idle_pins('0);
      s_q.dout <= 8'h00;
      s_q.doe <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flip-flops.
  assign req_ready_out = s_q.ready;
  assign done_out = s_q.done;
  assign fail_out = s_q.fail;
  assign rdata_out = s_q.rdata;
  assign pins_out = s_q.pins;
  assign data_pins_out = s_q.dout;
  assign data_pins_oe_out = s_q.doe;

endmodule
`default_nettype wire

// [testbench/uvmc_mem_model.sv]
// Behavioural byte memory that answers the programmer's pins.
`default_nettype none
module uvmc_mem_model
  import uvmc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] TYPE_CODE = 8'hC3 // Arbitrary value.
)
(
  // Pins from the programmer.
  input wire uvmc_pins_t pins_in,
  input wire logic [DATA_W-1:0] data_in,
  // Byte back to the programmer.
  output logic [DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last = 8'h00;
  logic drive;
  // The array starts erased.
  initial begin
    for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = ERASED_BYTE;
  end
  // A strobe fall writes only in program mode; bits can only clear.
  always @(negedge pins_in.program_strobe_n) begin
    if (pins_in.high_voltage_level && !pins_in.chip_sel_n &&
        pins_in.out_gate_n) begin
      mem[pins_in.address_pins] = mem[pins_in.address_pins] &
        data_in;
    end
  end
  // Output only with select and gate low and strobe high.
  always_comb begin
    drive = !pins_in.chip_sel_n && !pins_in.out_gate_n &&
      pins_in.program_strobe_n;
    val = mem[pins_in.address_pins];
    if (pins_in.identity_trigger_line) begin
      val = pins_in.address_pins[0] ? TYPE_CODE : MAKER_CODE;
    end
  end
  // A floating bus shows the inverse, so stale data never passes.
  always @* if (drive) last = val;
  assign data_out = drive ? val : ~last;
endmodule
`default_nettype wire

// [testbench/uvmc_ctrl_sva.sv]
// Checker of the programmer's pin sequencing toward the memory.
`default_nettype none
module uvmc_ctrl_sva
  import uvmc_pkg::*;
(
  // Watched ports.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire uvmc_pins_t pins_out,
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic data_pins_oe_out,
  input wire logic req_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [31:0] low_q;
  // Counts strobe-low cycles so each pulse width can be judged.
  always_ff @(posedge clk_in) begin
    low_q <= pins_out.program_strobe_n ? 32'h0 : low_q + 32'h1;
  end
  property p_strobe_cond;
    $fell(pins_out.program_strobe_n) |-> pins_out.high_voltage_level &&
      !pins_out.chip_sel_n && pins_out.out_gate_n && data_pins_oe_out;
  endproperty
  a_strobe_cond: assert property (p_strobe_cond)
    else $error("strobe fell outside program setup");
  property p_hold;
    !pins_out.program_strobe_n && !$past(pins_out.program_strobe_n) |->
      $stable(pins_out.address_pins) && $stable(data_pins_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address or data moved under the strobe");
  property p_width;
    $rose(pins_out.program_strobe_n) |-> low_q inside
      {[9500:10500], [95000:105000], [285000:7875000]};
  endproperty
  a_width: assert property (p_width)
    else $error("program pulse width out of range");
  property p_verify;
    pins_out.high_voltage_level && !pins_out.out_gate_n |->
      !pins_out.chip_sel_n && pins_out.program_strobe_n && !data_pins_oe_out;
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify pins wrong");
  property p_oe_gate;
    data_pins_oe_out |-> pins_out.out_gate_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("data driven while gate low");
  // While waiting for work the memory must sit in standby and inhibit.
  property p_idle;
    req_ready_out |-> pins_out.chip_sel_n && pins_out.program_strobe_n &&
      !pins_out.high_voltage_level && !data_pins_oe_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle pins not in standby");
  c_pulse: cover property ($rose(pins_out.program_strobe_n));
  c_ident: cover property ($rose(pins_out.identity_trigger_line));
  c_verify: cover property (pins_out.high_voltage_level &&
    !pins_out.out_gate_n);
endmodule
bind uvmc_ctrl uvmc_ctrl_sva u_sva (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .pins_out(pins_out),
  .data_pins_out(data_pins_out),
  .data_pins_oe_out(data_pins_oe_out),
  .req_ready_out(req_ready_out)
);
`default_nettype wire

// [testbench/test_uvmc_ctrl.sv]
// Self-checking bench for the memory programmer.
`default_nettype none
module test_uvmc_ctrl
  import uvmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVT = 8'hC3; // Arbitrary value.
  logic clk_in, resetn_in, req_valid_in, req_ready_out, done_out, fail_out;
  uvmc_req_t req_in;
  uvmc_pins_t pins_out;
  logic [DATA_W-1:0] rdata_out, data_pins_out, data_pins_in;
  logic data_pins_oe_out;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int ref_mem [int];
  uvmc_ctrl u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .done_out(done_out),
    .fail_out(fail_out), .rdata_out(rdata_out), .pins_out(pins_out),
    .data_pins_out(data_pins_out), .data_pins_oe_out(data_pins_oe_out),
    .data_pins_in(data_pins_in));
  uvmc_mem_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DEVT)) u_mem (
    .pins_in(pins_out), .data_in(data_pins_out), .data_out(data_pins_in));
  // Free-running clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // A hang costs a mismatch and ends the run.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until taken, then wait for the done pulse.
  task automatic run(input uvmc_cmd_t c, input logic [12:0] a,
                     input logic [7:0] d);
    req_in <= '{cmd: c, addr: a, data: d};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    while (req_ready_out !== 1'b1) @(posedge clk_in);
    req_valid_in <= 1'b0;
    @(posedge clk_in);
    while (done_out !== 1'b1) @(posedge clk_in);
  endtask
  task automatic rd(input logic [12:0] a);
    run(CMD_READ, a, 8'h00);
    chk(rdata_out, 8'(ref_mem.exists(a) ? ref_mem[a] : 255));
  endtask
  // Refused when a bit would have to rise; else bits only clear.
  task automatic prog(input uvmc_cmd_t c, input logic [12:0] a,
                      input logic [7:0] d);
    int old;
    old = ref_mem.exists(a) ? ref_mem[a] : 255;
    run(c, a, d);
    chk(8'(fail_out), 8'((~old & d & 255) != 0));
    if ((~old & d & 255) == 0) ref_mem[a] = old & d;
  endtask
  initial begin
    logic [12:0] a;
    logic [7:0] d;
    resetn_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    void'($urandom(32'hDB0F));
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    a = 13'($urandom);
    d = 8'($urandom) & 8'hFE;
    rd(a);
    prog(CMD_PROG_EXPRESS, a, d);
    rd(a);
    prog(CMD_PROG_EXPRESS, a, d | 8'h01);
    prog(CMD_PROG_FAST, a, d);
    rd(a ^ 13'h1);
    for (int i = 0; i < 2; i++) begin
      run(CMD_IDENTITY, 13'(i), 8'h00);
      chk(rdata_out, (i == 1) ? DEVT : MAKER);
    end
    // A reset in mid-command must drop the access and deselect the memory.
    req_in <= '{cmd: CMD_READ, addr: a, data: 8'h00};
    req_valid_in <= 1'b1;
    repeat (50) @(posedge clk_in);
    chk(8'(pins_out.chip_sel_n), 8'h00);
    req_valid_in <= 1'b0;
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    chk(8'(pins_out.chip_sel_n), 8'h01);
    run(CMD_STANDBY, a, 8'h00);
    chk(8'(pins_out.chip_sel_n), 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
